// ---- rtl/sxa_alu.sv ----
/*
 Execution datapath for five byte operations of an 8-bit core:
 subtract and xor with literal or file register, and nibble swap.
 Assumes one request per cycle from the decoder, which also fetches the
 addressed register value in the same cycle as the request strobe.
 Refused operation codes leave the accumulator and flags unchanged and raise no write-back or completion pulse.
*/
`timescale 1ns/100ps
module sxa_alu
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Request from decode
   input wire logic req_valid,
   input wire sxa_pkg::sxa_req_s req,
   // Accumulator and flags
   output logic [7:0] acc_q,
   output sxa_pkg::sxa_flags_s flags_q,
   // File register write-back
   output sxa_pkg::sxa_wb_s wb_q,
   // Completion pulse
   output logic done_q
);

   ////////////////////////////////////////////////////////////////////////
   // Result unit

   logic [7:0] result;
   sxa_pkg::sxa_flags_s cand;

   sxa_arith u_arith
   (
      .op(req.op),
      .acc(acc_q),
      .literal(req.literal),
      .reg_value(req.reg_value),
      .result(result),
      .flags(cand)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Unknown codes are dropped so no state moves on a decode fault
   function automatic logic op_known(input sxa_pkg::sxa_op_e op);
      case (op)
         sxa_pkg::SXA_OP_SUB_LIT,
         sxa_pkg::SXA_OP_XOR_LIT,
         sxa_pkg::SXA_OP_SUB_REG,
         sxa_pkg::SXA_OP_XOR_REG,
         sxa_pkg::SXA_OP_SWAP_REG: op_known = 1'b1;
         default: op_known = 1'b0;
      endcase
   endfunction : op_known

   // Literal forms always land in the accumulator
   function automatic logic op_literal(input sxa_pkg::sxa_op_e op);
      case (op)
         sxa_pkg::SXA_OP_SUB_LIT,
         sxa_pkg::SXA_OP_XOR_LIT: op_literal = 1'b1;
         default: op_literal = 1'b0;
      endcase
   endfunction : op_literal

   function automatic logic op_subtract(input sxa_pkg::sxa_op_e op);
      case (op)
         sxa_pkg::SXA_OP_SUB_LIT,
         sxa_pkg::SXA_OP_SUB_REG: op_subtract = 1'b1;
         default: op_subtract = 1'b0;
      endcase
   endfunction : op_subtract

   // Swap is the only taken operation that leaves the zero flag alone
   function automatic logic op_sets_zero(input sxa_pkg::sxa_op_e op);
      case (op)
         sxa_pkg::SXA_OP_SUB_LIT,
         sxa_pkg::SXA_OP_XOR_LIT,
         sxa_pkg::SXA_OP_SUB_REG,
         sxa_pkg::SXA_OP_XOR_REG: op_sets_zero = 1'b1;
         default: op_sets_zero = 1'b0;
      endcase
   endfunction : op_sets_zero

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   logic take;
   logic to_acc;
   logic to_reg;
   logic is_sub;
   logic sets_zero;

   // Target bit only matters for the file-register forms
   always_comb
   begin
      take = req_valid && op_known(req.op);
      to_acc = take && (op_literal(req.op) || req.dest == sxa_pkg::DEST_ACC);
      to_reg = take && !op_literal(req.op) && req.dest == sxa_pkg::DEST_REG;
      is_sub = take && op_subtract(req.op);
      sets_zero = take && op_sets_zero(req.op);
   end

   ////////////////////////////////////////////////////////////////////////
   // Accumulator

   logic [7:0] acc_d;

   always_comb
   begin
      acc_d = acc_q;
      if (to_acc)
      begin
         acc_d = result;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         acc_q <= sxa_pkg::ACC_RESET;
      end
      else
      begin
         acc_q <= acc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags

   sxa_pkg::sxa_flags_s flags_d;

   always_comb
   begin
      flags_d = flags_q;
      if (sets_zero)
      begin
         flags_d.zero = cand.zero;
      end
      // Xor and swap keep borrow and half-borrow from the last subtract
      if (is_sub)
      begin
         flags_d.borrow_out = cand.borrow_out;
         flags_d.half_borrow_bit = cand.half_borrow_bit;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         flags_q <= sxa_pkg::FLAGS_RESET;
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // File register write-back

   sxa_pkg::sxa_wb_s wb_d;

   // Pulse lasts one cycle; the file must take it then, there is no retry
   always_comb
   begin
      wb_d = '0;
      if (to_reg)
      begin
         wb_d.wr = 1'b1;
         wb_d.index = req.reg_index;
         wb_d.data = result;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wb_q <= '0;
      end
      else
      begin
         wb_q <= wb_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completion

   logic done_d;

   // One pulse per taken operation, none for refused codes
   always_comb
   begin
      done_d = take;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= done_d;
      end
   end

endmodule : sxa_alu

// ---- rtl/sxa_pkg.sv ----
/*
 Package for the subtract/xor/swap execution datapath: operation codes,
 flag layout, widths and reset values.
 Assumes the core decodes instructions and provides the operands itself.
*/
package sxa_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;

   // Operation select, Gray coded along the listed order
   typedef enum logic [2:0]
   {
      SXA_OP_NONE = 3'h0,
      SXA_OP_SUB_LIT = 3'h1,
      SXA_OP_XOR_LIT = 3'h3,
      SXA_OP_SUB_REG = 3'h2,
      SXA_OP_XOR_REG = 3'h6,
      SXA_OP_SWAP_REG = 3'h7
   } sxa_op_e;

   // Status flag positions within the 3-bit flag vector
   localparam int FLAG_BORROW = 2;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_ZERO = 0;

   localparam logic [2:0] FLAGS_RESET = 3'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_REG = 1'h1;

   // One issued operation
   typedef struct packed
   {
      sxa_op_e op;
      logic [7:0] literal;
      logic [7:0] reg_value;
      logic [6:0] reg_index;
      logic dest;
   } sxa_req_s;

   // Register write-back towards the file
   typedef struct packed
   {
      logic wr;
      logic [6:0] index;
      logic [7:0] data;
   } sxa_wb_s;

   typedef struct packed
   {
      logic borrow_out;
      logic half_borrow_bit;
      logic zero;
   } sxa_flags_s;

endpackage : sxa_pkg

// ---- rtl/sxa_arith.sv ----
/*
 Combinational result unit: computes result and flag candidates.
 Assumes the caller registers every output and picks which flags apply.
*/
`timescale 1ns/100ps
module sxa_arith
(
   // Operation
   input wire sxa_pkg::sxa_op_e op,
   input wire logic [7:0] acc,
   input wire logic [7:0] literal,
   input wire logic [7:0] reg_value,
   // Result
   output logic [7:0] result,
   output sxa_pkg::sxa_flags_s flags
);

   // Minuend minus accumulator; carry out is not-borrow
   function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
      sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
   endfunction : sub9

   function automatic logic [4:0] sub5(input logic [3:0] a, input logic [3:0] b);
      sub5 = {1'b0, a} + {1'b0, ~b} + 5'h01;
   endfunction : sub5

   logic [7:0] minuend;
   logic [8:0] diff;
   logic [4:0] low_diff;

   always_comb
   begin
      minuend = (op == sxa_pkg::SXA_OP_SUB_LIT) ? literal : reg_value;
      diff = sub9(minuend, acc);
      low_diff = sub5(minuend[3:0], acc[3:0]);
      case (op)
         sxa_pkg::SXA_OP_SUB_LIT,
         sxa_pkg::SXA_OP_SUB_REG: result = diff[7:0];
         sxa_pkg::SXA_OP_XOR_LIT: result = acc ^ literal;
         sxa_pkg::SXA_OP_XOR_REG: result = acc ^ reg_value;
         sxa_pkg::SXA_OP_SWAP_REG: result = {reg_value[3:0], reg_value[7:4]};
         default: result = acc;
      endcase
      flags.zero = (result == 8'h00);
      flags.borrow_out = diff[8];
      flags.half_borrow_bit = low_diff[4];
   end

endmodule : sxa_arith

// ---- bench/sxa_alu_properties.sv ----
/* Checker for sxa_alu port behaviour.
 Assumes one-cycle answer after a taken request. */
`timescale 1ns/100ps
module sxa_alu_properties
(
   // Ports watched
   input wire logic mclk,
   input wire logic rst,
   input wire logic req_valid,
   input wire sxa_pkg::sxa_req_s req,
   input wire logic [7:0] acc_q,
   input wire sxa_pkg::sxa_flags_s flags_q,
   input wire sxa_pkg::sxa_wb_s wb_q,
   input wire logic done_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   sequence s_reg_wb;
      wb_q.wr && wb_q.index == $past(req.reg_index) && $stable(acc_q);
   endsequence
   a_sub_lit: assert property (req_valid && req.op == sxa_pkg::SXA_OP_SUB_LIT |=>
      acc_q == $past(req.literal) - $past(acc_q)) else $error("sub literal wrong");
   a_xor_lit: assert property (req_valid && req.op == sxa_pkg::SXA_OP_XOR_LIT |=>
      acc_q == ($past(req.literal) ^ $past(acc_q)) && $stable(flags_q.borrow_out)) else $error("xor literal wrong");
   a_sub_borrow: assert property (req_valid && req.op == sxa_pkg::SXA_OP_SUB_REG |=>
      flags_q.borrow_out == ($past(req.reg_value) >= $past(acc_q))) else $error("borrow wrong");
   a_dest_reg: assert property (req_valid && req.dest && req.op inside {sxa_pkg::SXA_OP_SUB_REG,
      sxa_pkg::SXA_OP_XOR_REG, sxa_pkg::SXA_OP_SWAP_REG} |=> s_reg_wb) else $error("write-back wrong");
   a_xor_reg: assert property (req_valid && req.op == sxa_pkg::SXA_OP_XOR_REG && !req.dest |=>
      acc_q == ($past(req.reg_value) ^ $past(acc_q))) else $error("xor register wrong");
   a_swap_flags: assert property (req_valid && req.op == sxa_pkg::SXA_OP_SWAP_REG |=>
      $stable(flags_q)) else $error("swap touched flags");
   a_zero_flag: assert property (done_q && $past(req.op) != sxa_pkg::SXA_OP_SWAP_REG |->
      flags_q.zero == ((wb_q.wr ? wb_q.data : acc_q) == 8'h00)) else $error("zero flag wrong");
   a_swap_data: assert property (req_valid && req.op == sxa_pkg::SXA_OP_SWAP_REG && req.dest |=>
      wb_q.data == {$past(req.reg_value[3:0]), $past(req.reg_value[7:4])}) else $error("swap data wrong");
   a_half_borrow: assert property (req_valid && req.op == sxa_pkg::SXA_OP_SUB_REG |=>
      flags_q.half_borrow_bit == ($past(req.reg_value[3:0]) >= $past(acc_q[3:0]))) else $error("half borrow wrong");
   a_refused_op: assert property (req_valid && !(req.op inside {sxa_pkg::SXA_OP_SUB_LIT, sxa_pkg::SXA_OP_XOR_LIT,
      sxa_pkg::SXA_OP_SUB_REG, sxa_pkg::SXA_OP_XOR_REG, sxa_pkg::SXA_OP_SWAP_REG}) |=>
      !done_q && !wb_q.wr && $stable(acc_q) && $stable(flags_q)) else $error("refused code moved state");
endmodule : sxa_alu_properties
bind sxa_alu sxa_alu_properties u_props(.mclk, .rst, .req_valid, .req, .acc_q, .flags_q, .wb_q, .done_q);

// ---- bench/tb.sv ----
/* Directed bench for sxa_alu.
 Assumes the bench stands in for decode and register file. */
`timescale 1ns/100ps
module tb;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic req_valid = 1'h0;
   sxa_pkg::sxa_req_s req = '0;
   logic [7:0] acc_q;
   sxa_pkg::sxa_flags_s flags_q;
   sxa_pkg::sxa_wb_s wb_q;
   logic done_q;
   int fails = 0;
   int comparisons = 0;
   always #50 mclk = ~mclk;
   sxa_alu u_sxa_alu(.mclk, .rst, .req_valid, .req, .acc_q, .flags_q, .wb_q, .done_q);
   ////////////////////////////////////////////////////////////
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One-edge strobe, outputs settle after the next edge
   task run(input sxa_pkg::sxa_op_e op, input logic [7:0] k, input logic [7:0] f, input logic d);
      @(posedge mclk);
      req_valid <= 1'h1;
      req <= '{op, k, f, 7'h2a, d};
      @(posedge mclk);
      req_valid <= 1'h0;
      #1;
   endtask : run
   task summarize;
      $display("checks %0d bad %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////
   task t_lit;
      run(sxa_pkg::SXA_OP_XOR_LIT, 8'h13, 8'h00, 1'h1);
      chk({acc_q, 5'h0, flags_q}, 16'h1300);
      chk(wb_q, 16'h0000);
      chk({15'h0, done_q}, 16'h0001);
      run(sxa_pkg::SXA_OP_SUB_LIT, 8'h10, 8'h00, 1'h1);
      chk({acc_q, 5'h0, flags_q}, 16'hfd00);
      $display("literal ops done");
   endtask : t_lit
   task t_reg;
      run(sxa_pkg::SXA_OP_SUB_REG, 8'h00, 8'hfd, 1'h0);
      chk({acc_q, 5'h0, flags_q}, 16'h0007);
      run(sxa_pkg::SXA_OP_SUB_REG, 8'h00, 8'h05, 1'h1);
      chk(wb_q, 16'haa05);
      chk({acc_q, 5'h0, flags_q}, 16'h0006);
      run(sxa_pkg::SXA_OP_XOR_REG, 8'h00, 8'h5a, 1'h0);
      chk({acc_q, 5'h0, flags_q}, 16'h5a06);
      run(sxa_pkg::SXA_OP_SWAP_REG, 8'h00, 8'h3c, 1'h1);
      chk(wb_q, 16'haac3);
      chk({acc_q, 5'h0, flags_q}, 16'h5a06);
      $display("register ops done");
   endtask : t_reg
   task t_refuse;
      run(sxa_pkg::sxa_op_e'(3'h4), 8'h77, 8'h00, 1'h1);
      chk({acc_q, 5'h0, flags_q}, 16'h5a06);
      chk(wb_q, 16'h0000);
      chk({15'h0, done_q}, 16'h0000);
      run(sxa_pkg::SXA_OP_NONE, 8'h00, 8'h00, 1'h0);
      chk({acc_q, 5'h0, flags_q}, 16'h5a06);
      chk({15'h0, done_q}, 16'h0000);
      $display("refused ops done");
   endtask : t_refuse
   task t_b2b;
      @(posedge mclk);
      req_valid <= 1'h1;
      req <= '{sxa_pkg::SXA_OP_XOR_LIT, 8'h0f, 8'h00, 7'h2a, 1'h0};
      @(posedge mclk);
      req <= '{sxa_pkg::SXA_OP_SUB_LIT, 8'h20, 8'h00, 7'h2a, 1'h0};
      @(posedge mclk);
      req_valid <= 1'h0;
      #1;
      chk({acc_q, 5'h0, flags_q}, 16'hcb00);
      $display("back to back done");
   endtask : t_b2b
   initial
   begin
      repeat (4) @(posedge mclk);
      rst <= 1'h0;
      t_lit;
      t_reg;
      t_refuse;
      t_b2b;
      summarize;
   end
   initial
   begin
      #100000;
      fails++;
      summarize;
   end
endmodule : tb
